// ---- logic/lamp_safety_pkg.sv ----
// Shared constants and types for the status lamp and safety stop block
package lamp_safety_pkg;
	// Clock rate and timing
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned SHOW_TIME_MS = 2000;
	localparam int unsigned SHOW_CYCLES = CLK_HZ / 1000 * SHOW_TIME_MS;
	localparam int unsigned BLINK_HALF_MS = 250;
	localparam int unsigned BLINK_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;
	localparam int unsigned TIMER_W = 32;

	// Reset values
	localparam logic LAMP_RST = 1'b0;
	localparam logic POWER_OK_RST = 1'b0;
	localparam logic BRAKE_RST = 1'b1;
	localparam logic DOOR_LATCH_RST = 1'b1;

	// Operating modes on the mode selector input
	typedef enum logic [1:0] {
		MODE_RUN = 2'h0,
		MODE_JOG = 2'h1,
		MODE_DEV = 2'h2,
		MODE_TEST = 2'h3
	} op_mode_t;

	// Save result display phase
	typedef enum logic [1:0] {
		SHOW_NONE,
		SHOW_OK,
		SHOW_FAIL
	} show_t;
endpackage

// ---- logic/lamp_safety.sv ----
// Front panel lamp driver with safety stop and dynamic brake logic
`timescale 1ns/1ps

module lamp_safety #(
	parameter int unsigned SHOW_COUNT = lamp_safety_pkg::SHOW_CYCLES,
	parameter int unsigned BLINK_COUNT = lamp_safety_pkg::BLINK_CYCLES,
	parameter int unsigned POS_W = 24
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Controller condition
	input wire logic STARTUP_DONE,
	input wire logic ERROR_ACTIVE,
	input wire logic WARNING_ACTIVE,
	input wire logic RECOVERY_MODE,
	input wire logic [1:0] OP_MODE,
	// Status save to USB memory
	input wire logic SAVE_BUSY,
	input wire logic SAVE_OK,
	input wire logic SAVE_FAIL,
	// Safety inputs
	input wire logic ESTOP_IN,
	input wire logic DOOR_OPEN,
	input wire logic LATCH_RELEASE,
	input wire logic ENABLE_SW,
	input wire logic LOW_POWER_CMD,
	// Detector flags
	input wire logic ENC_CABLE_LOST,
	input wire logic MOTOR_OVERLOAD,
	input wire logic TORQUE_IRREGULAR,
	input wire logic SPEED_ERROR,
	input wire logic SPEED_OVERFLOW,
	input wire logic [POS_W-1:0] POS_ACTUAL,
	input wire logic [POS_W-1:0] POS_COMMAND,
	input wire logic [POS_W-1:0] POS_MARGIN,
	input wire logic WATCHDOG_EXPIRED,
	input wire logic CROSS_MISMATCH,
	input wire logic CHECKSUM_ERROR,
	input wire logic DRIVER_OVERHEAT,
	input wire logic RELAY_WELDED,
	input wire logic RELAY_JUNCTION_ERR,
	input wire logic RELAY_OPEN_FAULT,
	input wire logic OVER_VOLTAGE,
	input wire logic SUPPLY_DROP,
	input wire logic TEMP_ANOMALY,
	input wire logic FAN_FAULT,
	// Lamps
	output logic LAMP_FAULT,
	output logic LAMP_HALT,
	output logic LAMP_JOG,
	output logic LAMP_RUN,
	output logic LAMP_DEV,
	// Motor power and brake
	output logic MOTOR_POWER_EN,
	output logic MOTOR_LOW_POWER,
	output logic DYN_BRAKE,
	output logic ESTOP_STATE,
	output logic POS_OVERFLOW,
	output logic DOOR_LATCHED,
	output logic TEMP_WARN,
	output logic FAN_WARN
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [lamp_safety_pkg::TIMER_W-1:0] blink_cnt;
		logic blink;
		logic [lamp_safety_pkg::TIMER_W-1:0] show_cnt;
		lamp_safety_pkg::show_t show;
		logic door_latch;
		logic estop;
		logic pos_ovf;
		logic lamp_fault;
		logic lamp_halt;
		logic lamp_jog;
		logic lamp_run;
		logic lamp_dev;
		logic power_en;
		logic low_power;
		logic brake;
		logic temp_warn;
		logic fan_warn;
	} state_t;

	state_t st_q;
	state_t st_d;

	localparam logic [lamp_safety_pkg::TIMER_W-1:0] BLINK_LAST =
		lamp_safety_pkg::TIMER_W'(BLINK_COUNT - 1);
	localparam logic [lamp_safety_pkg::TIMER_W-1:0] SHOW_LAST =
		lamp_safety_pkg::TIMER_W'(SHOW_COUNT - 1);

	// ==========================================================
	// Position difference
	logic [POS_W-1:0] pos_diff;

	always_comb begin
		if (POS_ACTUAL >= POS_COMMAND) begin
			pos_diff = POS_ACTUAL - POS_COMMAND;
		end else begin
			pos_diff = POS_COMMAND - POS_ACTUAL;
		end
	end

	// ==========================================================
	// Mode decode
	// Every two-bit selector code is a legal mode, so the lamp case
	// below needs no default. The named jog term keeps the door
	// logic readable, since jog is the only mode past an open door.
	logic mode_jog;

	assign mode_jog = OP_MODE == lamp_safety_pkg::MODE_JOG;

	// ==========================================================
	// Brake sources
	// Grouped by the detector family that raises them, so that a
	// new flag lands in one place. The brake is a plain OR with no
	// memory: it lets go one clock after the last source clears, and the
	// motor power grant follows the same sum. A user who needs the
	// brake held must latch the flag upstream.
	logic pos_over;
	logic drive_stop;
	logic servo_stop;
	logic cpu_stop;
	logic relay_stop;
	logic supply_stop;
	logic brake_sum;

	assign pos_over = pos_diff > POS_MARGIN;

	// Emergency stop and the motor driver's own detectors
	assign drive_stop = ESTOP_IN | ENC_CABLE_LOST | MOTOR_OVERLOAD
		| TORQUE_IRREGULAR | CHECKSUM_ERROR | DRIVER_OVERHEAT;

	// Servo errors: speed and position following
	assign servo_stop = SPEED_ERROR | SPEED_OVERFLOW | pos_over;

	// Processor supervision and cross-check
	assign cpu_stop = WATCHDOG_EXPIRED | CROSS_MISMATCH;

	// Relay contact supervision
	assign relay_stop = RELAY_WELDED | RELAY_JUNCTION_ERR
		| RELAY_OPEN_FAULT;

	// Supply faults; over-voltage brakes, and so does a supply drop
	assign supply_stop = OVER_VOLTAGE | SUPPLY_DROP;

	// Temperature anomaly and fan faults are left out on purpose
	assign brake_sum = drive_stop | servo_stop | cpu_stop | relay_stop
		| supply_stop;

	// ==========================================================
	// Lamp conditions
	// Each level of the lamp priority as one term. The next state
	// logic walks them from the top, so a lower level only shows
	// when every level above it is quiet. Both blink terms use the
	// registered phase, so every blinking lamp flips on the same
	// edge and the panel never shows lamps out of step.
	logic boot_or_save;
	logic warn_blink;

	assign boot_or_save = !STARTUP_DONE | SAVE_BUSY;
	assign warn_blink = WARNING_ACTIVE & st_q.blink;

	// ==========================================================
	// Next state
	always_comb begin
		logic brake_req;
		logic mode_blink;
		lamp_safety_pkg::op_mode_t mode;
		brake_req = 1'b0;
		mode_blink = 1'b0;
		mode = lamp_safety_pkg::op_mode_t'(OP_MODE);
		st_d = st_q;

		// Shared blink timebase for every lamp
		if (st_q.blink_cnt >= BLINK_LAST) begin
			st_d.blink_cnt = '0;
			st_d.blink = ~st_q.blink;
		end else begin
			st_d.blink_cnt = st_q.blink_cnt + 1'b1;
		end
		mode_blink = st_q.blink;

		// Save result hold; a fresh result restarts the two seconds.
		// Failure is tested first so it wins when both pulses coincide.
		if (SAVE_FAIL) begin
			st_d.show = lamp_safety_pkg::SHOW_FAIL;
			st_d.show_cnt = '0;
		end else if (SAVE_OK) begin
			st_d.show = lamp_safety_pkg::SHOW_OK;
			st_d.show_cnt = '0;
		end else if (st_q.show != lamp_safety_pkg::SHOW_NONE) begin
			if (st_q.show_cnt >= SHOW_LAST) begin
				st_d.show = lamp_safety_pkg::SHOW_NONE;
				st_d.show_cnt = '0;
			end else begin
				st_d.show_cnt = st_q.show_cnt + 1'b1;
			end
		end

		// Emergency stop condition follows the inputs
		st_d.estop = ESTOP_IN;

		// Door latch: set wins over release, release needs a closed door
		if (DOOR_OPEN) begin
			st_d.door_latch = 1'b1;
		end else if (LATCH_RELEASE) begin
			st_d.door_latch = 1'b0;
		end

		st_d.pos_ovf = pos_over;

		// Sum of every brake source, grouped above
		brake_req = brake_sum;
		st_d.brake = brake_req;

		// Reported only, no brake
		st_d.temp_warn = TEMP_ANOMALY;
		st_d.fan_warn = FAN_FAULT;

		// Motor power grant
		if (ESTOP_IN || brake_req) begin
			st_d.power_en = 1'b0;
		end else if (DOOR_OPEN || st_d.door_latch) begin
			// Jog with enable held is the only way past an open door
			st_d.power_en = DOOR_OPEN && mode_jog && ENABLE_SW;
		end else begin
			st_d.power_en = 1'b1;
		end
		st_d.low_power = LOW_POWER_CMD
			| (DOOR_OPEN & st_d.power_en);

		// Lamps, highest priority first
		st_d.lamp_halt = ESTOP_IN;
		st_d.lamp_fault = 1'b0;
		st_d.lamp_jog = 1'b0;
		st_d.lamp_run = 1'b0;
		st_d.lamp_dev = 1'b0;
		if (st_d.show == lamp_safety_pkg::SHOW_FAIL) begin
			st_d.lamp_fault = 1'b1;
			st_d.lamp_jog = 1'b1;
			st_d.lamp_run = 1'b1;
			st_d.lamp_dev = 1'b1;
		end else if (st_d.show == lamp_safety_pkg::SHOW_OK) begin
			// Fault lamp held dark even with an error present
			st_d.lamp_jog = 1'b1;
			st_d.lamp_run = 1'b1;
			st_d.lamp_dev = 1'b1;
		end else if (boot_or_save) begin
			st_d.lamp_fault = ERROR_ACTIVE;
			st_d.lamp_jog = mode_blink;
			st_d.lamp_run = mode_blink;
			st_d.lamp_dev = mode_blink;
		end else if (RECOVERY_MODE) begin
			st_d.lamp_fault = 1'b1;
			st_d.lamp_jog = 1'b1;
			st_d.lamp_dev = 1'b1;
		end else if (SUPPLY_DROP) begin
			st_d.lamp_fault = ERROR_ACTIVE;
			st_d.lamp_jog = 1'b1;
			st_d.lamp_run = 1'b1;
		end else begin
			// Error steady outranks the warning blink
			st_d.lamp_fault = ERROR_ACTIVE
				| warn_blink;
			unique case (mode)
				lamp_safety_pkg::MODE_TEST: st_d.lamp_jog = 1'b1;
				lamp_safety_pkg::MODE_JOG: st_d.lamp_jog = st_q.blink;
				lamp_safety_pkg::MODE_RUN: st_d.lamp_run = st_q.blink;
				lamp_safety_pkg::MODE_DEV: st_d.lamp_dev = st_q.blink;
			endcase
		end
	end

	// ==========================================================
	// Registers
	// The door latch comes out of reset set and the brake engaged:
	// after a reset only jog with enable past an open door may move until the door is seen closed
	// and a release is given. The cost is one release step at every
	// start, which the controller issues as part of its startup.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			st_q <= '0;
			st_q.show <= lamp_safety_pkg::SHOW_NONE;
			st_q.door_latch <= lamp_safety_pkg::DOOR_LATCH_RST;
			st_q.power_en <= lamp_safety_pkg::POWER_OK_RST;
			st_q.brake <= lamp_safety_pkg::BRAKE_RST;
			st_q.lamp_fault <= lamp_safety_pkg::LAMP_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Outputs, all straight from flip-flops
	// Every output lags its inputs by exactly one clock, which keeps
	// the lamps glitch free; the stop path pays that one cycle too.
	assign LAMP_FAULT = st_q.lamp_fault;
	assign LAMP_HALT = st_q.lamp_halt;
	assign LAMP_JOG = st_q.lamp_jog;
	assign LAMP_RUN = st_q.lamp_run;
	assign LAMP_DEV = st_q.lamp_dev;
	assign MOTOR_POWER_EN = st_q.power_en;
	assign MOTOR_LOW_POWER = st_q.low_power;
	assign DYN_BRAKE = st_q.brake;
	assign ESTOP_STATE = st_q.estop;
	assign POS_OVERFLOW = st_q.pos_ovf;
	assign DOOR_LATCHED = st_q.door_latch;
	assign TEMP_WARN = st_q.temp_warn;
	assign FAN_WARN = st_q.fan_warn;

endmodule

// ---- test/lamp_safety_checker.sv ----
// Port-level checks for the lamp and safety block
`timescale 1ns/1ps
module lamp_safety_checker #(
	parameter int unsigned SHOW_COUNT = 20,
	parameter int unsigned POS_W = 24
) (
	input wire logic CLK, SYS_RST, STARTUP_DONE, RECOVERY_MODE, SAVE_BUSY,
	input wire logic SAVE_OK, SAVE_FAIL, ESTOP_IN, DOOR_OPEN, LATCH_RELEASE,
	input wire logic LOW_POWER_CMD, SUPPLY_DROP, ENC_CABLE_LOST, OVER_VOLTAGE,
	input wire logic WATCHDOG_EXPIRED, CROSS_MISMATCH, RELAY_WELDED,
	input wire logic [POS_W-1:0] POS_ACTUAL, POS_COMMAND, POS_MARGIN,
	input wire logic LAMP_FAULT, LAMP_HALT, LAMP_JOG, LAMP_RUN, LAMP_DEV,
	input wire logic MOTOR_POWER_EN, MOTOR_LOW_POWER, DYN_BRAKE,
	input wire logic ESTOP_STATE, POS_OVERFLOW, DOOR_LATCHED
);
	int sc;
	logic [POS_W-1:0] d;
	assign d = POS_ACTUAL > POS_COMMAND ? POS_ACTUAL - POS_COMMAND
		: POS_COMMAND - POS_ACTUAL;
	// Two spare cycles so the end of a save display never trips a check
	always_ff @(posedge CLK) begin
		if (SYS_RST) sc <= 0;
		else if (SAVE_OK || SAVE_FAIL) sc <= SHOW_COUNT + 2;
		else if (sc > 0) sc <= sc - 1;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_idle;
		STARTUP_DONE && !SAVE_BUSY && !SAVE_OK && !SAVE_FAIL && sc == 0;
	endsequence
	sequence s_show;
		LAMP_JOG && LAMP_RUN && LAMP_DEV;
	endsequence
	AST_ESTOP: assert property (ESTOP_IN |=> DYN_BRAKE &&
		!MOTOR_POWER_EN && ESTOP_STATE && LAMP_HALT) else $error("estop");
	AST_SAVE_OK: assert property (SAVE_OK && !SAVE_FAIL |=>
		s_show ##0 !LAMP_FAULT) else $error("save ok lamps");
	AST_SAVE_FAIL: assert property (SAVE_FAIL |=>
		s_show ##0 LAMP_FAULT) else $error("save fail lamps");
	AST_HOLD: assert property (sc > 3 |=> s_show)
		else $error("save display short");
	AST_BOOT: assert property (!STARTUP_DONE && sc == 0 && !SAVE_OK
		&& !SAVE_FAIL |=> LAMP_JOG == LAMP_RUN && LAMP_RUN == LAMP_DEV)
		else $error("boot blink");
	AST_RECOV: assert property (s_idle ##0 RECOVERY_MODE |=>
		LAMP_FAULT && LAMP_JOG && LAMP_DEV && !LAMP_RUN)
		else $error("recovery lamps");
	AST_DROP: assert property (s_idle ##0 SUPPLY_DROP &&
		!RECOVERY_MODE |=> LAMP_JOG && LAMP_RUN && DYN_BRAKE)
		else $error("supply drop");
	AST_DOOR: assert property (DOOR_LATCHED && (DOOR_OPEN ||
		!LATCH_RELEASE) || DOOR_OPEN |=> DOOR_LATCHED) else $error("latch");
	AST_LOWP: assert property (LOW_POWER_CMD |=>
		MOTOR_LOW_POWER || !MOTOR_POWER_EN) else $error("low power");
	AST_POS: assert property (1 |=>
		POS_OVERFLOW == $past(d > POS_MARGIN)) else $error("pos overflow");
	AST_BRAKE: assert property (ENC_CABLE_LOST || OVER_VOLTAGE ||
		WATCHDOG_EXPIRED || CROSS_MISMATCH || RELAY_WELDED |=>
		DYN_BRAKE && !MOTOR_POWER_EN) else $error("brake source");
endmodule
bind lamp_safety lamp_safety_checker #(.SHOW_COUNT(SHOW_COUNT),
	.POS_W(POS_W)) CHK (.*);

// ---- test/panel_switches.sv ----
// Operator panel model: stop switch, door switch, mode key, enable
`timescale 1ns/1ps
module panel_switches (
	input wire logic clk,
	input wire logic [2:0] want,
	input wire logic [1:0] want_mode,
	output logic estop_q,
	output logic door_q,
	output logic enable_q,
	output logic [1:0] mode_q
);
	logic [4:0] hold;
	initial {estop_q, door_q, enable_q, mode_q} = 5'h00;
	// Wishes are taken at the edge, contacts move just after it
	always @(posedge clk) begin
		hold = {want[0], want[1], want[2] && want_mode == 2'h1, want_mode};
		#1;
		{estop_q, door_q, enable_q, mode_q} = hold;
	end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the lamp and safety block
`timescale 1ns/1ps
module tb_top;
	localparam int SC = 20;
	logic CLK = 0, SYS_RST = 1, STARTUP_DONE = 0, ERROR_ACTIVE = 0;
	logic WARNING_ACTIVE = 0, RECOVERY_MODE = 0, SAVE_BUSY = 0, SAVE_OK = 0;
	logic SAVE_FAIL = 0, LATCH_RELEASE = 0, LOW_POWER_CMD = 0;
	logic TEMP_ANOMALY = 0, FAN_FAULT = 0, es, dr, en, x;
	logic [1:0] md, wm = 2'h0;
	logic [2:0] w = 3'h0;
	logic [13:0] f = 14'h0000;
	logic [23:0] POS_ACTUAL = 24'h000000, POS_COMMAND = 24'h000000;
	logic [23:0] POS_MARGIN = 24'hFFFFFF;
	logic [15:0] r = 16'h5F29;
	logic LAMP_FAULT, LAMP_HALT, LAMP_JOG, LAMP_RUN, LAMP_DEV, TEMP_WARN;
	logic MOTOR_POWER_EN, MOTOR_LOW_POWER, DYN_BRAKE, ESTOP_STATE, FAN_WARN;
	logic POS_OVERFLOW, DOOR_LATCHED;
	int bad_count = 0, comparisons = 0, d;
	initial forever #4 CLK = ~CLK;
	panel_switches PM (.clk(CLK), .want(w), .want_mode(wm), .estop_q(es),
		.door_q(dr), .enable_q(en), .mode_q(md));
	lamp_safety #(.SHOW_COUNT(SC), .BLINK_COUNT(4)) DUT (.CLK, .SYS_RST,
		.STARTUP_DONE, .ERROR_ACTIVE, .WARNING_ACTIVE, .RECOVERY_MODE,
		.OP_MODE(md), .SAVE_BUSY, .SAVE_OK, .SAVE_FAIL, .ESTOP_IN(es),
		.DOOR_OPEN(dr), .LATCH_RELEASE, .ENABLE_SW(en), .LOW_POWER_CMD,
		.ENC_CABLE_LOST(f[0]), .MOTOR_OVERLOAD(f[1]), .TORQUE_IRREGULAR(f[2]),
		.SPEED_ERROR(f[3]), .SPEED_OVERFLOW(f[4]), .POS_ACTUAL, .POS_COMMAND,
		.POS_MARGIN, .WATCHDOG_EXPIRED(f[5]), .CROSS_MISMATCH(f[6]),
		.CHECKSUM_ERROR(f[7]), .DRIVER_OVERHEAT(f[8]), .RELAY_WELDED(f[9]),
		.RELAY_JUNCTION_ERR(f[10]), .RELAY_OPEN_FAULT(f[11]),
		.OVER_VOLTAGE(f[12]), .SUPPLY_DROP(f[13]), .TEMP_ANOMALY, .FAN_FAULT,
		.LAMP_FAULT, .LAMP_HALT, .LAMP_JOG, .LAMP_RUN, .LAMP_DEV,
		.MOTOR_POWER_EN, .MOTOR_LOW_POWER, .DYN_BRAKE, .ESTOP_STATE,
		.POS_OVERFLOW, .DOOR_LATCHED, .TEMP_WARN, .FAN_WARN);
	// ====
	// Helpers
	function automatic logic [15:0] nx(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic ck(string n, logic e, logic g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic st(int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic results;
		$display("Counts %0d compared %0d bad", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		results();
	end
	// ====
	// Scenarios
	initial begin
		st(2);
		ck("rst_brake", 1'b1, DYN_BRAKE);
		SYS_RST = 0;
		st(3);
		x = LAMP_JOG;
		st(4);
		ck("boot", !x, LAMP_JOG);
		ck("boot_run_dev", !x, LAMP_RUN & LAMP_DEV);
		{STARTUP_DONE, LATCH_RELEASE, TEMP_ANOMALY, FAN_FAULT} = 4'hF;
		st(3);
		LATCH_RELEASE = 0;
		ck("latch", 1'b0, DOOR_LATCHED);
		ck("warn", 1'b1, TEMP_WARN & FAN_WARN & !DYN_BRAKE);
		for (int i = 0; i < 14; i++) begin
			f = 14'h0001 << i;
			st(2);
			ck("brake", 1'b1, DYN_BRAKE & !MOTOR_POWER_EN);
			if (i == 13) ck("drop", 1'b1, LAMP_JOG & LAMP_RUN);
		end
		f = 14'h0000;
		w = 3'h1;
		st(3);
		ck("halt", 1'b1, LAMP_HALT & ESTOP_STATE & !MOTOR_POWER_EN);
		w = 3'h0;
		$display("Test brakes ended");
		for (int i = 0; i < 16; i++) begin
			r = nx(r);
			POS_ACTUAL = {8'h00, r};
			r = nx(r);
			POS_COMMAND = {8'h00, r};
			POS_MARGIN = {9'h000, r[14:0]};
			st(2);
			d = int'(POS_ACTUAL) - int'(POS_COMMAND);
			if (d < 0) d = -d;
			ck("pos", d > int'(POS_MARGIN), POS_OVERFLOW);
		end
		POS_MARGIN = 24'hFFFFFF;
		ERROR_ACTIVE = 1;
		for (int k = 0; k < 2; k++) begin
			{SAVE_OK, SAVE_FAIL} = k ? 2'h1 : 2'h2;
			st(1);
			{SAVE_OK, SAVE_FAIL} = 2'h0;
			ck("show", 1'b1, LAMP_DEV & LAMP_JOG & LAMP_RUN);
			ck("show_err", k == 1, LAMP_FAULT);
			st(SC - 2);
			ck("hold", 1'b1, LAMP_JOG);
			st(4);
			ck("end", 1'b0, LAMP_JOG | !LAMP_FAULT);
		end
		{ERROR_ACTIVE, WARNING_ACTIVE, SAVE_BUSY} = 3'h3;
		st(1);
		x = LAMP_JOG;
		st(4);
		ck("busy", !x, LAMP_JOG);
		SAVE_BUSY = 0;
		st(2);
		x = LAMP_FAULT;
		st(4);
		ck("warn_blink", !x, LAMP_FAULT);
		wm = 2'h3;
		RECOVERY_MODE = 1;
		st(3);
		ck("recov", 1'b1, LAMP_FAULT & LAMP_JOG & LAMP_DEV & !LAMP_RUN);
		RECOVERY_MODE = 0;
		WARNING_ACTIVE = 0;
		st(6);
		ck("test_mode", 1'b1, LAMP_JOG);
		wm = 2'h1;
		w = 3'h2;
		LATCH_RELEASE = 1;
		st(3);
		ck("door", 1'b1, DOOR_LATCHED & !MOTOR_POWER_EN);
		w = 3'h6;
		st(3);
		ck("jog_door", 1'b1, MOTOR_POWER_EN & MOTOR_LOW_POWER);
		w = 3'h0;
		st(3);
		ck("release", 1'b0, DOOR_LATCHED);
		LOW_POWER_CMD = 1;
		st(2);
		ck("low_pwr", 1'b1, MOTOR_LOW_POWER);
		$display("Test lamps ended");
		results();
	end
endmodule
